// ==== dv/ees_chk_checker.sv ====
`timescale 1ns/1ps
// ----
// Port checker of the front end.
// ----
module ees_chk
(
  input wire logic        mclk,             // Clock.
  input wire logic        resetn,           // Reset.
  input wire logic        por_active,       // Supply low.
  input wire logic        write_protect_in, // Protect.
  input wire logic        sda_out,          // Pin level.
  input wire logic        sda_oe,           // Pin pull.
  input wire logic        busy,             // Selected.
  input wire logic        wr_valid,         // Word held.
  input wire logic        wr_ready,         // Sink ready.
  input wire logic [15:0] wr_addr,          // Word address.
  input wire logic [7:0]  wr_data,          // Word data.
  input wire logic        wr_commit,        // Write start.
  input wire logic        rd_strobe,        // Byte fetched.
  input wire logic        lock_cmd,         // Lock request.
  input wire logic        id_locked         // Lock state.
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  a_od_low: assert property (sda_oe |-> !sda_out)
    else $error("data pin driven high");
  a_por_quiet: assert property (por_active [*6] |-> !sda_oe && !busy)
    else $error("response while supply low");
  a_oe_busy: assert property (sda_oe |-> busy || $past(busy))
    else $error("data pulled while not addressed");
  a_wp_block: assert property
    (write_protect_in [*6] ##0 !wr_valid |=> !wr_valid)
    else $error("write entered while protected");
  a_lock_keep: assert property (id_locked |=> id_locked)
    else $error("lock lost");
  a_lock_set: assert property (lock_cmd |=> id_locked)
    else $error("lock not taken");
  a_buf_hold: assert property (wr_valid && !wr_ready |=>
    wr_valid && $stable(wr_addr) && $stable(wr_data))
    else $error("stalled word changed");
  a_commit_one: assert property (wr_commit |=> !wr_commit)
    else $error("commit longer than one cycle");
  a_commit_idle: assert property (wr_commit |-> !busy)
    else $error("commit inside a frame");
  a_strobe_gap: assert property (rd_strobe |=> !rd_strobe [*8])
    else $error("fetch without serial clock");
  // Main scenarios reached.
  c_commit: cover property (wr_commit);
  c_fetch: cover property (rd_strobe);
  c_stall: cover property (wr_valid && !wr_ready ##1 wr_valid);
  c_lock: cover property (id_locked);
endmodule : ees_chk

bind ees_front ees_chk u_chk (.mclk(mclk), .resetn(resetn),
  .por_active(por_active), .write_protect_in(write_protect_in),
  .sda_out(sda_out), .sda_oe(sda_oe), .busy(busy), .wr_valid(wr_valid),
  .wr_ready(wr_ready), .wr_addr(wr_addr), .wr_data(wr_data),
  .wr_commit(wr_commit), .rd_strobe(rd_strobe), .lock_cmd(lock_cmd),
  .id_locked(id_locked));

// ==== dv/ees_mst.sv ====
`timescale 1ns/1ps
// ----
// Bus master; clock idles high between frames.
// ----
module ees_mst
(
  output logic      scl,     // Serial clock.
  output logic      sda_low, // Pulls data low.
  input  wire logic sda      // Resolved wire.
);
  int lo = 12; // Data delay in the low phase; larger is slower.
  initial scl = 1'b1;
  initial sda_low = 1'b0;
  // One bit: data set while low, sampled while high.
  task automatic bit_io(input logic b, output logic r);
    #(lo) sda_low = !b;
    #12 scl = 1'b1;
    #12 r = sda;
    #12 scl = 1'b0;
  endtask : bit_io
  // Start, also repeated.
  task automatic start;
    #12 sda_low = 1'b0;
    #12 scl = 1'b1;
    #12 sda_low = 1'b1;
    #12 scl = 1'b0;
  endtask : start
  // Stop leaves the slave in standby.
  task automatic stop;
    #12 sda_low = 1'b1;
    #12 scl = 1'b1;
    #12 sda_low = 1'b0;
    #12;
  endtask : stop
  // Byte out, MSB first, then the ack slot.
  task automatic wb(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask : wb
  // Byte in; the last one is not acked.
  task automatic rb(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(1'b1, d[i]);
    bit_io(last, r);
  endtask : rb
endmodule : ees_mst

// ==== dv/tb.sv ====
`timescale 1ns/1ps
// ----
// Bench of the front end.
// ----
module tb;
  import ees_pkg::*;
  localparam logic [3:0] TYP = 4'h5; // Arbitrary value.
  localparam logic [3:0] IDT = 4'h6; // Arbitrary value.
  logic        mclk = 1'b0;     // Clock.
  logic        resetn = 1'b0;   // Reset.
  logic        por = 1'b1;      // Supply low.
  logic        wp = 1'b0;       // Protect.
  logic        wr_ready = 1'b0; // Sink ready.
  logic        lock_cmd = 1'b0; // Lock.
  logic [2:0]  strap = 3'h5;    // Straps.
  logic [15:0] wr_addr, rd_addr;
  logic [7:0]  wr_data;
  logic        sda_out, sda_oe, wr_valid, wr_id_page, wr_commit;
  logic        rd_id_page, rd_strobe, id_locked, busy;
  wire         scl, m_low;
  wire         sda = !(sda_oe | m_low); // Open drain with pull-up.
  wire   [7:0] rd_data = rd_addr[7:0] ^ 8'h3C; // Array stand-in.
  int          err_count = 0, n_compared = 0, n_commit = 0;
  always #2.5 mclk = ~mclk;
  always @(posedge mclk) if (wr_commit === 1'b1) n_commit++;
  ees_front #(.MEM_TYPE_CODE(TYP), .ID_TYPE_CODE(IDT)) uut (.mclk(mclk),
    .resetn(resetn), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .select_strap_pins(strap), .write_protect_in(wp),
    .por_active(por), .wr_valid(wr_valid), .wr_ready(wr_ready),
    .wr_addr(wr_addr), .wr_data(wr_data), .wr_id_page(wr_id_page),
    .wr_commit(wr_commit), .rd_data_in(rd_data), .rd_addr(rd_addr),
    .rd_id_page(rd_id_page), .rd_strobe(rd_strobe), .lock_cmd(lock_cmd),
    .id_lock_nv(1'b0), .id_locked(id_locked), .busy(busy));
  ees_mst m (.scl(scl), .sda_low(m_low), .sda(sda));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      err_count++;
      $display("wrong value at %0t: %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic summarize;
    if (err_count == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : summarize
  // Start, select byte, ack check.
  task automatic sel(input logic [3:0] t, input logic [2:0] s,
                     input logic rw, input logic exp);
    logic a;
    m.start();
    m.wb({t, s, rw}, a);
    chk(a, exp);
  endtask : sel
  task automatic wd(input logic [7:0] d, input logic exp);
    logic a;
    m.wb(d, a);
    chk(a, exp);
  endtask : wd
  // Supply low: no answer.
  task automatic t_por;
    @(negedge mclk) por = 1'b1;
    repeat (6) @(negedge mclk);
    sel(TYP, strap, 1'b0, 1'b0);
    m.stop();
    chk(busy, 1'b0);
    @(negedge mclk) por = 1'b0;
    repeat (6) @(negedge mclk);
  endtask : t_por
  // Page write, stalled buffer, page wrap.
  task automatic t_write;
    sel(TYP, strap, 1'b0, 1'b1);
    wd(8'h12, 1'b1);
    wd(8'h3F, 1'b1);
    wd(8'hC7, 1'b1);
    wd(8'h88, 1'b1);
    wd(8'h99, 1'b0);
    m.stop();
    repeat (4) @(negedge mclk);
    chk(n_commit, 16'h0001);
    chk(wr_addr, 16'h123F);
    chk(wr_data, 8'hC7);
    @(negedge mclk) wr_ready = 1'b1;
    @(negedge mclk) wr_ready = 1'b0;
    chk(wr_addr, 16'h1220);
    chk(wr_data, 8'h88);
    @(negedge mclk) wr_ready = 1'b1;
    @(negedge mclk) chk(wr_valid, 1'b0);
  endtask : t_write
  // Each strap bit wrong, then the type.
  task automatic t_select;
    for (int i = 0; i < 3; i++)
    begin
      sel(TYP, strap ^ (3'h1 << i), 1'b0, 1'b0);
      repeat (5) @(negedge mclk);
      chk(busy, 1'b0);
      m.stop();
    end
    sel(TYP ^ 4'h8, strap, 1'b1, 1'b0);
    m.stop();
  endtask : t_select
  // Protected: data refused.
  task automatic t_protect;
    @(negedge mclk) wp = 1'b1;
    repeat (4) @(negedge mclk);
    sel(TYP, strap, 1'b0, 1'b1);
    wd(8'h00, 1'b1);
    wd(8'h05, 1'b1);
    wd(8'h5A, 1'b0);
    m.stop();
    repeat (4) @(negedge mclk);
    chk(wr_valid, 1'b0);
    chk(n_commit, 16'h0001);
    wp = 1'b0;
  endtask : t_protect
  // Random read, zero straps, slow master.
  task automatic t_read;
    logic [7:0] d;
    @(negedge mclk) strap = 3'h0;
    m.lo = 20;
    repeat (4) @(negedge mclk);
    sel(TYP, 3'h0, 1'b0, 1'b1);
    wd(8'h04, 1'b1);
    wd(8'h21, 1'b1);
    sel(TYP, 3'h0, 1'b1, 1'b1);
    m.rb(1'b0, d);
    chk(d, 8'h1D);
    m.rb(1'b1, d);
    chk(d, 8'h1E);
    m.stop();
    m.lo = 12;
    @(negedge mclk) strap = 3'h5;
  endtask : t_read
  // Id page writable until locked.
  task automatic t_lock;
    @(negedge mclk) wr_ready = 1'b0;
    sel(IDT, strap, 1'b0, 1'b1);
    wd(8'h00, 1'b1);
    wd(8'h03, 1'b1);
    wd(8'h77, 1'b1);
    m.stop();
    repeat (4) @(negedge mclk);
    chk(wr_id_page, 1'b1);
    chk(rd_id_page, 1'b1);
    chk(wr_data, 8'h77);
    wr_ready = 1'b1;
    @(negedge mclk) lock_cmd = 1'b1;
    @(negedge mclk) lock_cmd = 1'b0;
    chk(id_locked, 1'b1);
    sel(IDT, strap, 1'b0, 1'b1);
    wd(8'h00, 1'b1);
    wd(8'h04, 1'b1);
    wd(8'h66, 1'b0);
    m.stop();
  endtask : t_lock
  initial
  begin
    repeat (6) @(negedge mclk);
    resetn = 1'b1;
    t_por();
    t_write();
    t_select();
    t_protect();
    t_read();
    t_lock();
    t_por();
    summarize();
  end
  // Guard against a hang.
  initial
  begin
    #400000;
    err_count++;
    summarize();
  end
endmodule : tb

// ==== src/ees_buf2.sv ====
`timescale 1ns/1ps
// ---------------------------------------------------------------------------
// Small ring buffer with valid and ready on both sides.
// ---------------------------------------------------------------------------
module ees_buf2
  import ees_pkg::*;
#(
  parameter int unsigned WIDTH = EES_WR_W,
  parameter int unsigned DEPTH = EES_BUF_DEPTH
)
(
  input  wire logic             mclk,      // System clock.
  input  wire logic             resetn,    // Asynchronous reset, active low.
  input  wire logic             in_valid,  // Source offers a word.
  output logic                  in_ready,  // Buffer has room.
  input  wire logic [WIDTH-1:0] in_data,   // Word from the source.
  output logic                  out_valid, // Buffer holds a word.
  input  wire logic             out_ready, // Sink takes the word.
  output logic      [WIDTH-1:0] out_data   // Oldest word.
);

  localparam int unsigned PW = $clog2(DEPTH);

  // Pointers wrap only for a power of two.
  generate
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
    begin : g_bad_depth
      $error("ees_buf2: DEPTH must be a power of two of at least 2");
    end
  endgenerate

  logic [WIDTH-1:0] mem_ff [DEPTH];  // Storage entries.
  logic [PW-1:0]    wr_ptr_ff;       // Next entry to fill.
  logic [PW-1:0]    rd_ptr_ff;       // Oldest entry.
  logic [PW:0]      count_ff;        // Entries in use.
  logic             push;            // A word enters this cycle.
  logic             pop;             // A word leaves this cycle.

  assign in_ready  = (count_ff != (PW+1)'(DEPTH));
  assign out_valid = (count_ff != '0);
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign out_data  = mem_ff[rd_ptr_ff];

  // Store a word; the array needs no reset.
  always_ff @(posedge mclk)
  begin
    if (push)
    begin
      mem_ff[wr_ptr_ff] <= in_data;
    end
  end

  // Move the pointers and the fill count.
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff  <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_ff <= wr_ptr_ff + PW'(1);
      end
      if (pop)
      begin
        rd_ptr_ff <= rd_ptr_ff + PW'(1);
      end
      if (push && !pop)
      begin
        count_ff <= count_ff + (PW+1)'(1);
      end
      else if (pop && !push)
      begin
        count_ff <= count_ff - (PW+1)'(1);
      end
    end
  end

endmodule : ees_buf2

// ==== src/ees_front.sv ====
`timescale 1ns/1ps
// Behaviour
// - Shift bits only on serial clock edges.
// - Drive data line low only, else release.
// - Straps give expected select bits b3..b1.
// - Open strap input reads as zero.
// - Chip-scale variant uses fixed straps 001.
// - Select matches only when all three equal.
// - Select byte: type, enables, R/W; MSB first.
// - Write protect high blocks all array writes.
// - Open write protect reads low, writes allowed.
// - Protected: ack select and address, nack data.
// - First address byte holds b15..b8, MSB first.
// - Ignore everything while power-on reset active.
// - Power-on reset again: reset, stop responding.
// - Extra 32-byte page, read-only once locked.
// - Read/write bit: one reads, zero writes.
// - Select mismatch: no ack, back to standby.
// - Two address bytes, high first, select byte.
module ees_front
  import ees_pkg::*;
#(
  parameter bit         WLCSP         = 1'b0, // Chip-scale variant.
  parameter bit         HAS_ID_PAGE   = 1'b1, // Identification page fitted.
  parameter logic [3:0] MEM_TYPE_CODE = 4'h5, // Arbitrary value.
  parameter logic [3:0] ID_TYPE_CODE  = 4'h6, // Arbitrary value.
  parameter int unsigned BUF_DEPTH    = EES_BUF_DEPTH
)
(
  input  wire logic                   mclk,              // System clock.
  input  wire logic                   resetn,            // Async reset, low.
  input  wire logic                   scl_in,            // Serial clock pin.
  input  wire logic                   sda_in,            // Serial data level.
  output logic                        sda_out,           // Always low.
  output logic                        sda_oe,            // Pull data low.
  input  wire logic [EES_STRAP_W-1:0] select_strap_pins, // Chip enables.
  input  wire logic                   write_protect_in,  // High blocks.
  input  wire logic                   por_active,        // Supply too low.
  output logic                        wr_valid,          // Write word ready.
  input  wire logic                   wr_ready,          // Array takes word.
  output logic      [EES_ADDR_W-1:0]  wr_addr,           // Write address.
  output logic      [EES_BYTE_W-1:0]  wr_data,           // Write data.
  output logic                        wr_id_page,        // Targets id page.
  output logic                        wr_commit,         // Start write cycle.
  input  wire logic [EES_BYTE_W-1:0]  rd_data_in,        // Byte at rd_addr.
  output logic      [EES_ADDR_W-1:0]  rd_addr,           // Read address.
  output logic                        rd_id_page,        // Reads id page.
  output logic                        rd_strobe,         // Byte fetched.
  input  wire logic                   lock_cmd,          // Lock id page.
  input  wire logic                   id_lock_nv,        // Stored lock state.
  output logic                        id_locked,         // Id page locked.
  output logic                        busy               // Device selected.
);

  // ---------------------------------------------------------------------------
  // Parameter checks.
  // ---------------------------------------------------------------------------
  generate
    if (BUF_DEPTH < 2)
    begin : g_bad_buf
      $error("ees_front: BUF_DEPTH must be at least 2");
    end
  endgenerate

  // ---------------------------------------------------------------------------
  // Input synchronisers and edge detection.
  // ---------------------------------------------------------------------------
  logic [EES_SYNC_W-1:0]  sync1_ff;     // First stage, read only by second.
  logic [EES_SYNC_W-1:0]  sync2_ff;     // Second stage, safe to use.
  logic                   scl_d_ff;     // Serial clock one cycle back.
  logic                   sda_d_ff;     // Serial data one cycle back.
  logic                   scl_s;        // Synchronised serial clock.
  logic                   sda_s;        // Synchronised serial data.
  logic [EES_STRAP_W-1:0] strap_s;      // Synchronised strap pins.
  logic                   wp_s;         // Synchronised write protect.
  logic                   por_s;        // Synchronised power-on reset.
  logic                   scl_rise;     // Serial clock rose.
  logic                   scl_fall;     // Serial clock fell.
  logic                   start_det;    // Start condition seen.
  logic                   stop_det;     // Stop condition seen.

  // Every pin passes two flip-flops first.
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      sync1_ff <= EES_SYNC_RST;
      sync2_ff <= EES_SYNC_RST;
    end
    else
    begin
      sync1_ff <= {por_active, write_protect_in, select_strap_pins,
                   sda_in, scl_in};
      sync2_ff <= sync1_ff;
    end
  end

  // Previous line levels, for edges.
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      scl_d_ff <= 1'b1;
      sda_d_ff <= 1'b1;
    end
    else
    begin
      scl_d_ff <= scl_s;
      sda_d_ff <= sda_s;
    end
  end

  assign scl_s    = sync2_ff[EES_SY_SCL];
  assign sda_s    = sync2_ff[EES_SY_SDA];
  assign strap_s  = sync2_ff[EES_SY_STRAP +: EES_STRAP_W];
  assign wp_s     = sync2_ff[EES_SY_WP];
  assign por_s    = sync2_ff[EES_SY_POR];
  // The serial clock is the only timing reference for every bit.
  assign scl_rise = scl_s & ~scl_d_ff;
  assign scl_fall = ~scl_s & scl_d_ff;
  // Data moving while the clock is high: Start, Stop.
  assign start_det = scl_s & scl_d_ff & sda_d_ff & ~sda_s;
  assign stop_det  = scl_s & scl_d_ff & ~sda_d_ff & sda_s;

  // ---------------------------------------------------------------------------
  // Protocol state and byte decoding.
  // ---------------------------------------------------------------------------
  ees_state_t             state_ff;     // Current protocol phase.
  ees_state_t             after_ff;     // Phase after the ack slot.
  ees_state_t             dec_state;    // Phase chosen for a full byte.
  ees_state_t             nxt_state;    // Phase taken at end of ack slot.
  logic [2:0]             bit_cnt_ff;   // Data bits taken in this byte.
  logic [EES_BYTE_W-1:0]  shift_ff;     // Received bits, MSB first.
  logic [EES_BYTE_W-1:0]  tx_ff;        // Byte being sent to the master.
  logic [EES_ADDR_W-1:0]  addr_ff;      // Byte address counter.
  logic                   ack_phase_ff; // In the ninth bit of a byte.
  logic                   ack_live_ff;  // Ninth clock low phase reached.
  logic                   ack_ok_ff;    // Acknowledge this byte.
  logic                   mack_ff;      // Master acked our byte.
  logic                   id_sel_ff;    // Identification page selected.
  logic                   wr_any_ff;    // A byte was taken this frame.
  logic                   lock_ff;      // Lock done since reset.
  logic [EES_BYTE_W-1:0]  byte_in;      // Byte completed at this edge.
  logic [EES_STRAP_W-1:0] strap_exp;    // Expected chip enable bits.
  logic                   type_mem;     // Type field names the array.
  logic                   type_id;      // Type field names the id page.
  logic                   dev_match;    // Chip enable bits agree.
  logic                   dec_ack;      // Ack decision for the byte.
  logic                   dec_push;     // Byte goes into the buffer.
  logic                   active;       // A frame is addressing us.
  logic                   byte_done;    // Eighth data bit sampled.
  logic                   ack_start;    // Ack slot begins.
  logic                   ack_end;      // Ack slot ends.
  logic                   load_tx;      // Fetch a byte to send.
  logic                   buf_ready;    // Buffer has room.

  // An open strap pad is pulled down and reads 0;
  // the chip-scale variant uses fixed straps.
  assign strap_exp = WLCSP ? EES_WLCSP_STRAP : strap_s;
  assign id_locked = lock_ff | id_lock_nv;
  assign active    = !por_s && !start_det && !stop_det &&
                     state_ff != ST_IDLE && state_ff != ST_IGNORE;
  assign byte_done = active & scl_rise & ~ack_phase_ff &
                     (bit_cnt_ff == EES_LAST_BIT);
  assign ack_start = active & scl_fall & ack_phase_ff & ~ack_live_ff;
  assign ack_end   = active & scl_fall & ack_live_ff;
  // A read goes on while the master acks.
  assign nxt_state = (state_ff == ST_RDATA && !mack_ff) ? ST_IGNORE
                                                        : after_ff;
  assign load_tx   = ack_end & (nxt_state == ST_RDATA);
  assign busy      = (state_ff != ST_IDLE) && (state_ff != ST_IGNORE);

  // Decide what a completed byte means in the current phase.
  always_comb
  begin
    byte_in   = {shift_ff[EES_BYTE_W-2:0], sda_s};
    dev_match = (byte_in[3:1] == strap_exp);
    type_mem  = (byte_in[7:4] == MEM_TYPE_CODE);
    type_id   = HAS_ID_PAGE && (byte_in[7:4] == ID_TYPE_CODE);
    dec_state = ST_IGNORE;
    dec_ack   = 1'b0;
    dec_push  = 1'b0;
    case (state_ff)
      ST_DEVSEL:
      begin
        // A mismatch gives no ack and leaves the bus alone.
        if ((type_mem || type_id) && dev_match)
        begin
          dec_ack   = 1'b1;
          dec_state = (byte_in[0] == EES_RW_READ) ? ST_RDATA
                                                   : ST_ADDR_HI;
        end
      end
      ST_ADDR_HI:
      begin
        // Address bytes are acked even under write protect.
        dec_ack   = 1'b1;
        dec_state = ST_ADDR_LO;
      end
      ST_ADDR_LO:
      begin
        dec_ack   = 1'b1;
        dec_state = ST_WDATA;
      end
      ST_WDATA:
      begin
        // Protect, a locked page or a full buffer refuse the byte.
        dec_state = ST_WDATA;
        dec_push  = !wp_s && !(id_sel_ff && id_locked) &&
                    buf_ready;
        dec_ack   = dec_push;
      end
      ST_RDATA:
      begin
        // The master acks our bytes; we only release the line.
        dec_state = ST_RDATA;
      end
      default:
      begin
        dec_state = ST_IGNORE;
      end
    endcase
  end

  // Phase, bit count and ack slot tracking.
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_ff     <= ST_IDLE;
      after_ff     <= ST_IDLE;
      bit_cnt_ff   <= '0;
      ack_phase_ff <= 1'b0;
      ack_live_ff  <= 1'b0;
      ack_ok_ff    <= 1'b0;
    end
    else if (por_s || stop_det)
    begin
      // Power-on reset holds the slave in standby.
      state_ff     <= ST_IDLE;
      bit_cnt_ff   <= '0;
      ack_phase_ff <= 1'b0;
      ack_live_ff  <= 1'b0;
    end
    else if (start_det)
    begin
      // A Start, repeated or not, reopens device selection unless power-on reset is active.
      state_ff     <= ST_DEVSEL;
      bit_cnt_ff   <= '0;
      ack_phase_ff <= 1'b0;
      ack_live_ff  <= 1'b0;
    end
    else if (active && scl_rise && !ack_phase_ff)
    begin
      if (byte_done)
      begin
        bit_cnt_ff   <= '0;
        ack_phase_ff <= 1'b1;
        ack_ok_ff    <= dec_ack;
        after_ff     <= dec_state;
      end
      else
      begin
        bit_cnt_ff <= bit_cnt_ff + 3'h1;
      end
    end
    else if (ack_start)
    begin
      ack_live_ff <= 1'b1;
    end
    else if (ack_end)
    begin
      ack_phase_ff <= 1'b0;
      ack_live_ff  <= 1'b0;
      state_ff     <= nxt_state;
    end
  end

  // Bits shift in MSB first; the master's ack is sampled.
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      shift_ff <= '0;
      mack_ff  <= 1'b0;
    end
    else if (active && scl_rise)
    begin
      if (!ack_phase_ff)
      begin
        shift_ff <= byte_in;
      end
      else if (state_ff == ST_RDATA)
      begin
        mack_ff <= ~sda_s;
      end
    end
  end

  // Address counter: loaded high byte first, stepped per data byte.
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      addr_ff   <= '0;
      id_sel_ff <= 1'b0;
    end
    else if (byte_done && state_ff == ST_DEVSEL && dec_ack)
    begin
      id_sel_ff <= type_id;
    end
    else if (byte_done && state_ff == ST_ADDR_HI)
    begin
      addr_ff[15:8] <= byte_in;
    end
    else if (byte_done && state_ff == ST_ADDR_LO)
    begin
      addr_ff[7:0] <= byte_in;
    end
    else if ((byte_done && dec_push) || (load_tx && id_sel_ff))
    begin
      // Writes and page reads roll over inside their page.
      addr_ff[EES_PAGE_OFS_W-1:0] <= addr_ff[EES_PAGE_OFS_W-1:0] +
                                     EES_PAGE_OFS_W'(1);
    end
    else if (load_tx)
    begin
      addr_ff <= addr_ff + EES_ADDR_W'(1);
    end
  end

  // Data line driver: it only ever pulls low.
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      sda_oe <= 1'b0;
      tx_ff  <= '0;
    end
    else if (!active)
    begin
      sda_oe <= 1'b0;
    end
    else if (ack_start)
    begin
      sda_oe <= ack_ok_ff;
    end
    else if (ack_end)
    begin
      // Put the first bit of a fetched byte out, or let go.
      sda_oe <= load_tx & ~rd_data_in[EES_BYTE_W-1];
      if (load_tx)
      begin
        tx_ff <= rd_data_in;
      end
    end
    else if (scl_fall && state_ff == ST_RDATA && !ack_phase_ff)
    begin
      sda_oe <= ~tx_ff[~bit_cnt_ff];
    end
  end

  assign sda_out    = 1'b0;
  assign rd_addr    = addr_ff;
  assign rd_id_page = id_sel_ff;

  // ---------------------------------------------------------------------------
  // Write path, commit pulse and page lock.
  // ---------------------------------------------------------------------------
  // Commit only for a Stop right after a data byte's ack slot.
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      wr_any_ff <= 1'b0;
      wr_commit <= 1'b0;
      rd_strobe <= 1'b0;
    end
    else
    begin
      wr_commit <= stop_det && !por_s && wr_any_ff &&
                   state_ff == ST_WDATA && !ack_phase_ff &&
                   bit_cnt_ff == EES_COMMIT_BIT;
      rd_strobe <= load_tx;
      if (por_s || start_det || stop_det)
      begin
        wr_any_ff <= 1'b0;
      end
      else if (byte_done && dec_push)
      begin
        wr_any_ff <= 1'b1;
      end
    end
  end

  // Once locked the page stays read-only until resetn clears it; power-on reset leaves it set.
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      lock_ff <= 1'b0;
    end
    else if (lock_cmd && HAS_ID_PAGE)
    begin
      lock_ff <= 1'b1;
    end
  end

  // Accepted bytes wait here so an array stall loses none.
  ees_buf2 #(
    .WIDTH (EES_WR_W),
    .DEPTH (BUF_DEPTH)
  ) u_wr_buf (
    .mclk      (mclk),
    .resetn    (resetn),
    .in_valid  (byte_done & dec_push),
    .in_ready  (buf_ready),
    .in_data   ({id_sel_ff, addr_ff, byte_in}),
    .out_valid (wr_valid),
    .out_ready (wr_ready),
    .out_data  ({wr_id_page, wr_addr, wr_data})
  );

endmodule : ees_front

// ==== src/ees_pkg.sv ====
// ---------------------------------------------------------------------------
// Shared constants and types of the select and protect front end.
// ---------------------------------------------------------------------------
package ees_pkg;

  // Width of the byte address.
  localparam int unsigned EES_ADDR_W = 16;
  // Bits in one byte.
  localparam int unsigned EES_BYTE_W = 8;
  // Strap input count.
  localparam int unsigned EES_STRAP_W = 3;
  // Fixed straps of the chip-scale variant.
  localparam logic [2:0] EES_WLCSP_STRAP = 3'h1;
  // Read/write bit value for a read.
  localparam logic EES_RW_READ = 1'b1;
  // Last data bit index.
  localparam logic [2:0] EES_LAST_BIT = 3'h7;
  // Bit count of the slot after an ack.
  localparam logic [2:0] EES_COMMIT_BIT = 3'h1;
  // Identification page size in bytes.
  localparam int unsigned EES_ID_PAGE_BYTES = 32;
  // Offset bits inside a page.
  localparam int unsigned EES_PAGE_OFS_W = $clog2(EES_ID_PAGE_BYTES);
  // Write buffer depth.
  localparam int unsigned EES_BUF_DEPTH = 2;
  // Buffered word: page flag, address, data.
  localparam int unsigned EES_WR_W = 1 + EES_ADDR_W + EES_BYTE_W;

  // ---------------------------------------------------------------------------
  // Layout of the synchroniser vector.
  // ---------------------------------------------------------------------------
  localparam int unsigned EES_SYNC_W    = 7;
  localparam int unsigned EES_SY_SCL    = 0;
  localparam int unsigned EES_SY_SDA    = 1;
  localparam int unsigned EES_SY_STRAP  = 2;
  localparam int unsigned EES_SY_WP     = 5;
  localparam int unsigned EES_SY_POR    = 6;
  // Reset: lines idle high, power-on reset active.
  localparam logic [6:0] EES_SYNC_RST = 7'h43;

  // Protocol phases of the slave.
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_DEVSEL,
    ST_ADDR_HI,
    ST_ADDR_LO,
    ST_WDATA,
    ST_RDATA,
    ST_IGNORE
  } ees_state_t;

endpackage : ees_pkg
